//--- design/eets_slave.sv
// Slave end of the two-wire EEPROM front end: conditions, bits, acks,
// control byte decode, word address, address counter, write timer.
// Assumes the memory array sits on the user ports and answers reads
// combinationally for o_mem_addr.
`include "eets_consts.svh"
`default_nettype none
module eets_slave
  import eets_pkg::*;
#(
  parameter int SPIKE_CYC = (`EETS_SPIKE_NS + `EETS_CLK_NS - 1) / `EETS_CLK_NS,
  parameter int HOLD_CYC = (`EETS_HOLD_NS + `EETS_CLK_NS - 1) / `EETS_CLK_NS,
  parameter int WR_PAGE_CYC = (`EETS_WR_MS * `EETS_NS_PER_MS) / `EETS_CLK_NS,
  // Device-type code; value is arbitrary
  parameter logic [3:0] TYPE_CODE = 4'h6
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  eets_if.dev bus,
  input wire logic i_select_strap_bit0,
  input wire logic i_select_strap_bit1,
  input wire logic i_select_strap_bit2,
  input wire logic [7:0] i_rd_data,
  output logic [12:0] o_mem_addr,
  output logic [7:0] o_wr_data,
  output logic o_wr_strobe,
  output logic o_rd_strobe,
  output logic o_busy
);
  localparam int SW = $clog2(SPIKE_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int CW = $clog2(WR_PAGE_CYC + 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic [1:0] filt_q;
  logic [1:0] prev_q;
  logic [2:0] strap_q;
  // Bit 0 scl, 1 sda, 4:2 straps; only stage 2 reads stage 1
  always_ff @(posedge i_clk_sys)
  begin
    pin_s1_q <= {i_select_strap_bit2, i_select_strap_bit1, i_select_strap_bit0,
                 bus.sda, bus.scl};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  // Straps are static; take them once stages 2 and 3 agree
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      strap_q <= 3'h0;
    else if (pin_s2_q[4:2] == pin_s3_q[4:2])
      strap_q <= pin_s3_q[4:2];
  end

  // ----------------------------------------------------------------
  // Spike filter on scl and sda
  // ----------------------------------------------------------------
  // A level must persist SPIKE_CYC cycles before it is believed
  for (genvar k = 0; k < 2; k++)
  begin : g_filt
    logic [SW-1:0] cnt_q;
    always_ff @(posedge i_clk_sys)
    begin
      if (!i_reset_n)
      begin
        cnt_q <= '0;
        filt_q[k] <= 1'b1;
      end
      else if (pin_s2_q[k] == pin_s3_q[k] && pin_s3_q[k] != filt_q[k])
      begin
        if (cnt_q == SW'(SPIKE_CYC - 1))
        begin
          filt_q[k] <= pin_s3_q[k];
          cnt_q <= '0;
        end
        else
          cnt_q <= cnt_q + 1'b1;
      end
      else
        cnt_q <= '0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      prev_q <= 2'h3;
    else
      prev_q <= filt_q;
  end

  // Edge and condition decode
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = filt_q[0] & ~prev_q[0];
  assign scl_fall = ~filt_q[0] & prev_q[0];
  assign start_det = filt_q[0] & prev_q[0] & prev_q[1] & ~filt_q[1];
  assign stop_det = filt_q[0] & prev_q[0] & ~prev_q[1] & filt_q[1];

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  eets_state_e state_q;
  logic [3:0] bit_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [4:0] ahi_q;
  logic [12:0] addr_q;
  logic [6:0] wr_bytes_q;
  logic mst_ack_q;
  logic pend_oe_q;
  logic busy_q;
  logic wr_go;
  logic ctrl_match;
  assign wr_go = stop_det & (state_q == ST_WDATA) & (wr_bytes_q != 7'h00);
  assign ctrl_match = (rx_q[`EETS_TYPE_FLD] == TYPE_CODE)
                    & (rx_q[`EETS_SEL_FLD] == strap_q) & ~busy_q;

  // Sampling on scl high edges, state moves on scl low edges
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ahi_q <= 5'h00;
      addr_q <= 13'h0000;
      wr_bytes_q <= 7'h00;
      mst_ack_q <= 1'b0;
      pend_oe_q <= 1'b0;
      o_wr_data <= 8'h00;
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
    end
    else
    begin
      o_wr_strobe <= 1'b0;
      o_rd_strobe <= 1'b0;
      if (stop_det)
      begin
        state_q <= ST_IDLE;
        bit_q <= 4'h0;
        pend_oe_q <= 1'b0;
      end
      else if (start_det)
      begin
        state_q <= ST_CTRL;
        // The Start's own scl fall is not a data bit; it wraps this to bit 0
        bit_q <= `EETS_PRE_BIT;
        wr_bytes_q <= 7'h00;
        pend_oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        // Bits are valid only while scl is high
        if (bit_q != `EETS_ACK_BIT)
          rx_q <= {rx_q[6:0], filt_q[1]};
        else
          mst_ack_q <= ~filt_q[1];
      end
      else if (scl_fall)
      begin
        if (bit_q == `EETS_LAST_BIT)
        begin
          bit_q <= `EETS_ACK_BIT;
          pend_oe_q <= 1'b1;
          case (state_q)
            ST_CTRL:
            begin
              if (!ctrl_match)
              begin
                state_q <= ST_IGNORE;
                pend_oe_q <= 1'b0;
              end
            end
            ST_ADDRH:
              ahi_q <= rx_q[`EETS_AHI_FLD];
            ST_ADDRL:
              addr_q <= {ahi_q, rx_q};
            ST_WDATA:
            begin
              o_wr_data <= rx_q;
              o_wr_strobe <= 1'b1;
              addr_q <= addr_q + 13'h0001;
              if (wr_bytes_q != `EETS_CACHE_BYTES)
                wr_bytes_q <= wr_bytes_q + 7'h01;
            end
            default:
              pend_oe_q <= 1'b0; // Read byte done or idle: leave line to master
          endcase
        end
        else if (bit_q == `EETS_ACK_BIT)
        begin
          bit_q <= 4'h0;
          pend_oe_q <= 1'b0;
          case (state_q)
            ST_CTRL:
            begin
              if (rx_q[`EETS_RW_BIT])
              begin
                state_q <= ST_RDATA;
                tx_q <= {i_rd_data[6:0], 1'b0};
                pend_oe_q <= ~i_rd_data[`EETS_MSB];
                o_rd_strobe <= 1'b1;
                addr_q <= addr_q + 13'h0001;
              end
              else
                state_q <= ST_ADDRH;
            end
            ST_ADDRH:
              state_q <= ST_ADDRL;
            ST_ADDRL:
              state_q <= ST_WDATA;
            ST_RDATA:
            begin
              if (mst_ack_q)
              begin
                tx_q <= {i_rd_data[6:0], 1'b0};
                pend_oe_q <= ~i_rd_data[`EETS_MSB];
                o_rd_strobe <= 1'b1;
                addr_q <= addr_q + 13'h0001;
              end
              else
                state_q <= ST_IGNORE;
            end
            default:
              state_q <= state_q;
          endcase
        end
        else
        begin
          bit_q <= bit_q + 4'h1;
          if (state_q == ST_RDATA)
          begin
            pend_oe_q <= ~tx_q[`EETS_MSB];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output hold timer on sda
  // ----------------------------------------------------------------
  // Delay after scl fall keeps the change out of the slow fall edge
  logic [HW-1:0] hold_q;
  logic sda_oe_q;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      hold_q <= '0;
      sda_oe_q <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      hold_q <= '0;
      sda_oe_q <= 1'b0;
    end
    else if (scl_fall)
      hold_q <= HW'(HOLD_CYC);
    else if (hold_q != '0)
    begin
      hold_q <= hold_q - 1'b1;
      if (hold_q == HW'(1))
        sda_oe_q <= pend_oe_q;
    end
  end
  assign bus.dev_sda_oe = sda_oe_q;
  assign bus.dev_sda_out = 1'b0;

  // ----------------------------------------------------------------
  // Self-timed write cycle
  // ----------------------------------------------------------------
  logic [3:0] pages_q;
  logic [CW-1:0] cyc_q;
  logic [6:0] page_sum;
  assign page_sum = (wr_bytes_q + `EETS_PAGE_ROUND) >> `EETS_PAGE_SHIFT;
  // Busy time is one page period per cached page
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      busy_q <= 1'b0;
      pages_q <= 4'h0;
      cyc_q <= '0;
    end
    else if (!busy_q)
    begin
      if (wr_go)
      begin
        busy_q <= 1'b1;
        pages_q <= page_sum[3:0];
        cyc_q <= CW'(WR_PAGE_CYC - 1);
      end
    end
    else if (cyc_q != '0)
      cyc_q <= cyc_q - 1'b1;
    else if (pages_q == 4'h1)
      busy_q <= 1'b0;
    else
    begin
      pages_q <= pages_q - 4'h1;
      cyc_q <= CW'(WR_PAGE_CYC - 1);
    end
  end
  assign o_busy = busy_q;
  assign o_mem_addr = addr_q;
endmodule : eets_slave
`default_nettype wire

//--- design/eets_consts.svh
// Named constants for the two-wire EEPROM front end, both ends.
// Assumes a 125 MHz system clock on each end.
`ifndef EETS_CONSTS_SVH
`define EETS_CONSTS_SVH
`define EETS_CLK_NS 8
`define EETS_SPIKE_NS 50
`define EETS_HOLD_NS 300
`define EETS_WR_MS 5
`define EETS_NS_PER_MS 1_000_000
`define EETS_SCL_KHZ 100
`define EETS_US_PER_S_KHZ 1_000_000
`define EETS_PAGE_SHIFT 3
`define EETS_PAGE_ROUND 7'h07
`define EETS_CACHE_BYTES 7'h40
`define EETS_LAST_BIT 4'h7
`define EETS_ACK_BIT 4'h8
`define EETS_PRE_BIT 4'hf
`define EETS_TYPE_FLD 7:4
`define EETS_SEL_FLD 3:1
`define EETS_RW_BIT 0
`define EETS_AHI_FLD 4:0
`define EETS_MSB 7
`endif

//--- design/eets_pkg.sv
// Types shared by the slave and master ends.
// Assumes eets_consts.svh is on the include path.
`default_nettype none
package eets_pkg;
  // Device protocol states
  typedef enum logic [6:0]
  {
    ST_IDLE = 7'h01,
    ST_CTRL = 7'h02,
    ST_ADDRH = 7'h04,
    ST_ADDRL = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_IGNORE = 7'h40
  } eets_state_e;
  // Master sequencer states
  typedef enum logic [3:0]
  {
    M_IDLE = 4'h1,
    M_START = 4'h2,
    M_STOP = 4'h4,
    M_BYTE = 4'h8
  } eets_mstate_e;
  // Master commands
  typedef enum logic [1:0]
  {
    CMD_START = 2'h0,
    CMD_STOP = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ = 2'h3
  } eets_cmd_e;
endpackage : eets_pkg
`default_nettype wire

//--- design/eets_if.sv
// Two-wire bus between master end and slave end.
// Open-drain: an enable high pulls the line low; lines resolve here.
`default_nettype none
interface eets_if;
  logic mst_scl_out;
  logic mst_scl_oe;
  logic mst_sda_out;
  logic mst_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = ~(mst_scl_oe & ~mst_scl_out);
  assign sda = ~((mst_sda_oe & ~mst_sda_out) | (dev_sda_oe & ~dev_sda_out));
  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport mst (input scl, input sda, output mst_scl_out, output mst_scl_oe,
               output mst_sda_out, output mst_sda_oe);
endinterface : eets_if
`default_nettype wire

//--- design/eets_master.sv
// Master end: byte-level sequencer generating scl, Start, Stop and bytes.
// Assumes a user that issues START, WRITE/READ bytes and STOP in order.
`include "eets_consts.svh"
`default_nettype none
module eets_master
  import eets_pkg::*;
#(
  parameter int QTR_CYC =
    (`EETS_US_PER_S_KHZ / (`EETS_SCL_KHZ * 4)) / `EETS_CLK_NS
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  eets_if.mst bus,
  input wire logic i_cmd_valid,
  input wire eets_cmd_e i_cmd,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_send_ack,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [7:0] o_rd_byte,
  output logic o_ack_seen
);
  localparam int QW = $clog2(QTR_CYC + 1);

  // ----------------------------------------------------------------
  // Sda sampler
  // ----------------------------------------------------------------
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_s3_q;
  logic sda_lvl_q;
  always_ff @(posedge i_clk_sys)
  begin
    sda_s1_q <= bus.sda;
    sda_s2_q <= sda_s1_q;
    sda_s3_q <= sda_s2_q;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      sda_lvl_q <= 1'b1;
    else if (sda_s2_q == sda_s3_q)
      sda_lvl_q <= sda_s3_q;
  end

  // ----------------------------------------------------------------
  // Quarter-bit sequencer
  // ----------------------------------------------------------------
  eets_mstate_e st_q;
  logic [QW-1:0] qcnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic ack_q;
  logic scl_oe_q;
  logic sda_oe_q;
  // Each bit spans four quarters: set data, raise, sample, lower
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      st_q <= M_IDLE;
      qcnt_q <= '0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      o_cmd_ready <= 1'b1;
      o_done <= 1'b0;
      o_rd_byte <= 8'h00;
      o_ack_seen <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      case (st_q)
        M_IDLE:
        begin
          if (i_cmd_valid)
          begin
            o_cmd_ready <= 1'b0;
            qcnt_q <= QW'(QTR_CYC - 1);
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= i_wr_byte;
            rd_q <= (i_cmd == CMD_READ);
            ack_q <= i_send_ack;
            case (i_cmd)
              CMD_START: st_q <= M_START;
              CMD_STOP: st_q <= M_STOP;
              default: st_q <= M_BYTE;
            endcase
          end
        end
        default:
        begin
          if (qcnt_q != '0)
            qcnt_q <= qcnt_q - 1'b1;
          else
          begin
            qcnt_q <= QW'(QTR_CYC - 1);
            ph_q <= ph_q + 2'h1;
            if (st_q == M_START)
            begin
              // Release sda before scl so a held ack cannot mimic Stop
              case (ph_q)
                2'h0: sda_oe_q <= 1'b0;
                2'h1: scl_oe_q <= 1'b0;
                2'h2: sda_oe_q <= 1'b1;
                default: scl_oe_q <= 1'b1;
              endcase
            end
            else if (st_q == M_STOP)
            begin
              case (ph_q)
                2'h0: sda_oe_q <= 1'b1;
                2'h1: scl_oe_q <= 1'b0;
                2'h2: sda_oe_q <= 1'b0;
                default: sda_oe_q <= 1'b0;
              endcase
            end
            else
            begin
              case (ph_q)
                2'h0:
                  if (bit_q != `EETS_ACK_BIT)
                    sda_oe_q <= ~rd_q & ~sh_q[`EETS_MSB];
                  else
                    sda_oe_q <= rd_q & ack_q;
                2'h1: scl_oe_q <= 1'b0;
                2'h2:
                  if (bit_q != `EETS_ACK_BIT)
                    o_rd_byte <= {o_rd_byte[6:0], sda_lvl_q};
                  else
                    o_ack_seen <= ~sda_lvl_q;
                default:
                begin
                  scl_oe_q <= 1'b1;
                  sh_q <= {sh_q[6:0], 1'b0};
                  bit_q <= bit_q + 4'h1;
                end
              endcase
            end
            // Last quarter ends the command; a byte ends after nine bits
            if (ph_q == 2'h3 && (st_q != M_BYTE || bit_q == `EETS_ACK_BIT))
            begin
              st_q <= M_IDLE;
              o_done <= 1'b1;
              o_cmd_ready <= 1'b1;
            end
          end
        end
      endcase
    end
  end
  assign bus.mst_scl_oe = scl_oe_q;
  assign bus.mst_sda_oe = sda_oe_q;
  assign bus.mst_scl_out = 1'b0;
  assign bus.mst_sda_out = 1'b0;
endmodule : eets_master
`default_nettype wire

//--- tb/eets_bus_chk.sv
// Assertions on the two-wire link between master end and slave end.
// Assumes the resolved lines and enables of eets_if, one clock domain.
`default_nettype none
module eets_bus_chk
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic mst_scl_out,
  input wire logic mst_scl_oe,
  input wire logic mst_sda_out,
  input wire logic mst_sda_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_p_q;
  logic sda_p_q;
  logic nack_q;
  logic [3:0] bit_q;
  logic start_w;
  logic stop_w;
  logic rise_w;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // ----------------------------------------
  // Bit framing
  // ----------------------------------------
  // Raw line edges; raw is fine since only design ends drive
  assign start_w = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_w = scl & scl_p_q & ~sda_p_q & sda;
  assign rise_w = scl & ~scl_p_q;
  always_ff @(posedge i_clk_sys)
  begin
    scl_p_q <= scl;
    sda_p_q <= sda;
  end
  // Nine rises per byte; Start re-frames the count
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n || start_w)
      bit_q <= 4'h0;
    else if (rise_w)
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
  end
  // Set by a high ack slot, held until the next condition
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n || start_w || stop_w)
      nack_q <= 1'b0;
    else if (rise_w && bit_q == 4'h8 && sda)
      nack_q <= 1'b1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  lines_released_a: assert property ($rose(i_reset_n) |-> !dev_sda_oe && !mst_sda_oe && !mst_scl_oe)
    else $error("line driven after reset");
  open_drain_a: assert property (!dev_sda_out && !mst_sda_out && !mst_scl_out)
    else $error("line driven high");
  only_master_cond_a: assert property ($changed(sda) && scl && $past(scl) |-> $changed(mst_sda_oe))
    else $error("slave made a condition");
  slave_low_change_a: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("slave pulled sda with scl high");
  slave_out_hold_a: assert property ($changed(dev_sda_oe) && !scl |-> !$past(scl, 2))
    else $error("slave changed sda too soon after scl fall");
  ack_stable_a: assert property (dev_sda_oe && scl |=> dev_sda_oe || !scl)
    else $error("slave released sda in scl high");
  nack_release_a: assert property (nack_q |-> !dev_sda_oe)
    else $error("slave drove sda after a missing ack");
  scl_high_time_a: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high too short");
  scl_low_time_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low too short");
endmodule : eets_bus_chk
`default_nettype wire

//--- tb/tb_eeprom_two_wire_slave_front_end.sv
// Bench joining master end and slave end over one eets_if.
// Assumes short timing parameters; memory is a pattern of the address.
`default_nettype none
module tb_eeprom_two_wire_slave_front_end
  import eets_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] TYP = 4'h6;
  localparam logic [2:0] SEL = 3'b110;
  localparam logic [7:0] CW = {TYP, SEL, 1'b0};
  localparam logic [7:0] CR = {TYP, SEL, 1'b1};
  logic i_clk_sys;
  logic i_reset_n;
  logic cmd_valid;
  eets_cmd_e cmd;
  logic [7:0] wr_byte;
  logic send_ack;
  logic cmd_ready;
  logic done;
  logic [7:0] rd_byte;
  logic ack_seen;
  logic [12:0] mem_addr;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic busy;
  logic [7:0] rd_data;
  logic [7:0] wr_d;
  logic [12:0] wr_a;
  int n_errors = 0;
  int n_compared = 0;
  int n_wr = 0;
  int n_rd = 0;
  int busy_n = 0;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  eets_if i_eets_if ();
  // Asymmetric straps so a swapped select order shows
  eets_slave #(.SPIKE_CYC(1), .HOLD_CYC(1), .WR_PAGE_CYC(300), .TYPE_CODE(TYP)) i_eets_slave (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(i_eets_if),
    .i_select_strap_bit0(SEL[0]), .i_select_strap_bit1(SEL[1]),
    .i_select_strap_bit2(SEL[2]), .i_rd_data(rd_data), .o_mem_addr(mem_addr),
    .o_wr_data(wr_data), .o_wr_strobe(wr_strobe), .o_rd_strobe(rd_strobe), .o_busy(busy));
  eets_master #(.QTR_CYC(12)) i_eets_master (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .bus(i_eets_if),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wr_byte(wr_byte), .i_send_ack(send_ack),
    .o_cmd_ready(cmd_ready), .o_done(done), .o_rd_byte(rd_byte), .o_ack_seen(ack_seen));
  eets_bus_chk i_eets_bus_chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .mst_scl_out(i_eets_if.mst_scl_out), .mst_scl_oe(i_eets_if.mst_scl_oe),
    .mst_sda_out(i_eets_if.mst_sda_out), .mst_sda_oe(i_eets_if.mst_sda_oe),
    .dev_sda_out(i_eets_if.dev_sda_out), .dev_sda_oe(i_eets_if.dev_sda_oe),
    .scl(i_eets_if.scl), .sda(i_eets_if.sda));
  // Memory stand-in: data is a known function of the address
  always_comb rd_data = mem_addr[7:0] ^ 8'h5a;
  always #4 i_clk_sys = ~i_clk_sys;
  // Strobe and busy monitors
  always @(posedge i_clk_sys)
  begin
    if (wr_strobe === 1'b1)
    begin
      n_wr++;
      wr_d = wr_data;
      wr_a = mem_addr;
    end
    if (rd_strobe === 1'b1) n_rd++;
    if (busy === 1'b1) busy_n++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit
  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val
  // One master command, entered just after an edge; waits for done
  task automatic issue(input eets_cmd_e c, input logic [7:0] b, input logic a);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= c;
    wr_byte <= b;
    send_ack <= a;
    do @(posedge i_clk_sys); while (cmd_ready !== 1'b1 && ++n < 100);
    cmd_valid <= 1'b0;
    do @(posedge i_clk_sys); while (done !== 1'b1 && ++n < 1000);
    cmp_bit("cmd done", 1'b1, done);
  endtask : issue
  task automatic wr(input logic [7:0] b, input logic exp_ack);
    issue(CMD_WRITE, b, 1'b0);
    cmp_bit("ack seen", exp_ack, ack_seen);
  endtask : wr
  task automatic rd(input logic a, input logic [7:0] exp);
    issue(CMD_READ, 8'h00, a);
    cmp_val("read byte", {8'h00, exp}, {8'h00, rd_byte});
  endtask : rd
  // Nine-byte write crosses a page, then a control byte while busy
  task automatic t_write();
    int n;
    issue(CMD_START, 8'h00, 1'b0);
    wr(CW, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h23, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      wr(8'h30 + 8'(i), 1'b1);
      cmp_val("write data", 16'(8'h30 + i), {8'h00, wr_d});
      cmp_val("write addr", 16'(13'h0124 + i), {3'h0, wr_a});
    end
    busy_n = 0;
    issue(CMD_STOP, 8'h00, 1'b0);
    issue(CMD_START, 8'h00, 1'b0);
    wr(CW, 1'b0);
    issue(CMD_STOP, 8'h00, 1'b0);
    n = 0;
    while ((busy_n == 0 || busy !== 1'b0) && n++ < 2000) @(posedge i_clk_sys);
    cmp_bit("busy span", 1'b1, logic'(busy_n >= 600 && busy_n <= 602));
    cmp_val("addr counter", 16'h012c, {3'h0, mem_addr});
  endtask : t_write
  // Wrong select then wrong type: no ack, no write, no busy
  task automatic t_mismatch();
    int n0;
    n0 = n_wr;
    issue(CMD_START, 8'h00, 1'b0);
    wr({TYP, 3'b011, 1'b0}, 1'b0);
    wr(8'h00, 1'b0);
    issue(CMD_STOP, 8'h00, 1'b0);
    issue(CMD_START, 8'h00, 1'b0);
    wr({TYP ^ 4'h1, SEL, 1'b0}, 1'b0);
    issue(CMD_STOP, 8'h00, 1'b0);
    cmp_val("write count", 16'(n0), 16'(n_wr));
    cmp_bit("busy", 1'b0, busy);
  endtask : t_mismatch
  // Random read with repeated Start, sequential byte, current read
  task automatic t_read();
    n_rd = 0;
    issue(CMD_START, 8'h00, 1'b0);
    wr(CW, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'hfe, 1'b1);
    issue(CMD_START, 8'h00, 1'b0);
    wr(CR, 1'b1);
    rd(1'b1, 8'hfe ^ 8'h5a);
    rd(1'b0, 8'hff ^ 8'h5a);
    issue(CMD_STOP, 8'h00, 1'b0);
    issue(CMD_START, 8'h00, 1'b0);
    wr(CR, 1'b1);
    rd(1'b0, 8'h00 ^ 8'h5a);
    issue(CMD_STOP, 8'h00, 1'b0);
    cmp_val("read loads", 16'h0003, 16'(n_rd));
    cmp_val("addr counter", 16'h0101, {3'h0, mem_addr});
  endtask : t_read
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    i_clk_sys = 1'b0;
    i_reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = CMD_START;
    wr_byte = 8'h00;
    send_ack = 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    // Idle bus long enough to settle the slave's filters
    repeat (20) @(posedge i_clk_sys);
    cmp_bit("ready", 1'b1, cmd_ready);
    cmp_bit("busy", 1'b0, busy);
    cmp_val("addr counter", 16'h0000, {3'h0, mem_addr});
    t_write();
    t_mismatch();
    t_read();
    report_and_stop();
  end
  // Watchdog: tests need about 12k cycles
  initial
  begin
    repeat (60000) @(posedge i_clk_sys);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_eeprom_two_wire_slave_front_end
`default_nettype wire
